// ---- aic_defines.svh ----
// Constants for the auxiliary input control block.
// Assumes inclusion by the package and the design modules.
`ifndef AIC_DEFINES_SVH
`define AIC_DEFINES_SVH
`define AIC_NUM_PORTS 6
`define AIC_SETTLE_W 10
`define AIC_CODE_W 14
`define AIC_RESULT_W 16
`define AIC_BIAS_AUTO0 2'h0
`define AIC_BIAS_AUTO1 2'h1
`define AIC_BIAS_OFF 2'h2
`define AIC_BIAS_ON 2'h3
`define AIC_TICK_NS 6000
`define AIC_CLK_NS 4
`define AIC_TICK_CYCLES (`AIC_TICK_NS / `AIC_CLK_NS)
`define AIC_TICK_W 11
`define AIC_CODE_FULL 14'h3FFF
`define AIC_ZERO_RESULT 16'h0000
`endif

// ---- aic_pkg.sv ----
// Types shared by the auxiliary input control block.
// Assumes aic_defines.svh is on the include path.
`include "aic_defines.svh"
package aic_pkg;
  typedef enum logic [1:0] {AIC_IDLE, AIC_PRE, AIC_RUN} aic_state_e;
  typedef struct packed {
    logic [`AIC_NUM_PORTS-1:0] measure_enable;
    logic [`AIC_NUM_PORTS-1:0] reference_select;
    logic [`AIC_NUM_PORTS-1:0] gpio_select;
    logic i2c_pins_select;
    logic [1:0] bias_output_mode;
    logic [`AIC_SETTLE_W-1:0] aux_settle_count;
  } aic_cfg_s;
  typedef struct packed {
    logic [`AIC_TICK_W-1:0] cnt_q;
    logic tick_q;
  } aic_tick_s;
endpackage : aic_pkg

// ---- aic_tick_gen.sv ----
// Free running 6 us tick generator.
// Assumes a 250 MHz core clock and a synchronous reset.
`timescale 1ns/1ps
`include "aic_defines.svh"
module aic_tick_gen (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  output logic TICK
);
  aic_pkg::aic_tick_s s_q;
  aic_pkg::aic_tick_s s_d;
  localparam logic [`AIC_TICK_W-1:0] LAST = `AIC_TICK_W'(`AIC_TICK_CYCLES - 1);
  always_comb begin
    s_d = s_q;
    s_d.tick_q = 1'b0;
    if (s_q.cnt_q == LAST) begin
      s_d.cnt_q = '0;
      s_d.tick_q = 1'b1;
    end else begin
      s_d.cnt_q = s_q.cnt_q + `AIC_TICK_W'(1);
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign TICK = s_q.tick_q;
endmodule : aic_tick_gen

// ---- aic_aux_ctrl.sv ----
// Auxiliary input control: bias output, settling delay, results, protection, pin muxing.
// Assumes configuration arrives as plain ports written by the host link logic,
// and that the analog front end reports conversions and overvoltage events.
//
// Functional notes
// - bias codes 00/01 acquisition, 10 off, 11 on.
// - settling delay is count times 6 us per measured port.
// - non-deterministic scans settle alongside first scan.
// - deterministic scans settle before acquisition begins.
// - oversampled 14-bit value stored per channel.
// - result in bits 15:2, low bits zero.
// - at or above reference saturates full scale.
// - mixed references allowed, per-type thresholds selected.
// - overvoltage opens input, sets alert; rewrite clears.
// - summary alert is OR of six alerts.
// - gpio select overrides measure; else gpio tristated.
// - i2c select maps pins 0,1 to SDA,SCL.
// - i2c mode zeroes results 0 and 1.
`timescale 1ns/1ps
`include "aic_defines.svh"
module aic_aux_ctrl (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire aic_pkg::aic_cfg_s CFG,
  input wire logic CFG_WRITE,
  input wire logic DETERMINISTIC,
  input wire logic ACQ_START,
  input wire logic ACQ_END,
  input wire logic FIRST_SCAN_DONE,
  input wire logic CONV_VALID,
  input wire logic [2:0] CONV_CHANNEL,
  input wire logic [`AIC_CODE_W:0] CONV_CODE,
  input wire logic [`AIC_NUM_PORTS-1:0] OVERVOLT,
  output logic BIAS_OUTPUT_PIN,
  output logic SETTLE_DONE,
  output logic ACQ_GO,
  output logic AUX_CONV_START,
  output logic [`AIC_NUM_PORTS-1:0] AUX_PATH_OPEN,
  output logic [`AIC_NUM_PORTS-1:0] AUX_MEASURE_ACTIVE,
  output logic [`AIC_NUM_PORTS-1:0] USE_ABSOLUTE_THRESH,
  output logic [`AIC_NUM_PORTS-1:0] GPIO_DRIVER_EN,
  output logic I2C_ENABLE,
  output logic [`AIC_NUM_PORTS-1:0] AUX_PROTECT_ALERT,
  output logic AUX_PROTECT_ALERT_ANY,
  output logic [6*`AIC_RESULT_W-1:0] AUX_RESULT_REGISTER
);

  // ****************************************
  // Functions and state
  // ****************************************

  // Clamps the front-end code to full scale and packs it into the result word.
  function automatic logic [`AIC_RESULT_W-1:0] pack_result(input logic [`AIC_CODE_W:0] code);
    logic [`AIC_CODE_W-1:0] sat;
    sat = code[`AIC_CODE_W] ? `AIC_CODE_FULL : code[`AIC_CODE_W-1:0];
    pack_result = {sat, 2'b00};
  endfunction : pack_result

  // Whole state of the block; every output is read from the registered copy.
  typedef struct packed {
    aic_pkg::aic_state_e st;
    logic [`AIC_SETTLE_W+2:0] remain;
    logic pre_done;
    logic scan_seen;
    logic settle_done;
    logic acq_go;
    logic conv_start;
    logic bias;
    logic [`AIC_NUM_PORTS-1:0] alert;
    logic alert_any;
    logic [`AIC_NUM_PORTS-1:0] open_path;
    logic [`AIC_NUM_PORTS-1:0] active;
    logic [`AIC_NUM_PORTS-1:0] absolute;
    logic [`AIC_NUM_PORTS-1:0] gpio_drv;
    logic i2c;
    logic [5:0][`AIC_RESULT_W-1:0] result;
  } st_s;

  st_s s_q;
  st_s s_d;
  logic tick;
  logic [`AIC_NUM_PORTS-1:0] aux_sel;
  logic [2:0] n_en;

  // One free-running tick paces the settling counter.
  aic_tick_gen aic_tick_gen_i (
    .CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST),
    .TICK(tick)
  );

  // ****************************************
  // Next-state logic
  // ****************************************

  always_comb begin
    s_d = s_q;
    s_d.acq_go = 1'b0;
    s_d.conv_start = 1'b0;
    // A port is measured only when it is neither a GPIO nor an I2C pin.
    aux_sel = CFG.measure_enable & ~CFG.gpio_select;
    if (CFG.i2c_pins_select) begin
      aux_sel[1:0] = 2'b00;
    end
    // The settling delay scales with the number of measured ports.
    n_en = 3'h0;
    for (int i = 0; i < `AIC_NUM_PORTS; i++) begin
      n_en = n_en + 3'(aux_sel[i]);
    end
    s_d.active = aux_sel;
    s_d.gpio_drv = CFG.gpio_select;
    s_d.i2c = CFG.i2c_pins_select;
    if (CFG.i2c_pins_select) begin
      s_d.gpio_drv[1:0] = 2'b00;
    end
    s_d.absolute = CFG.reference_select;

    // Non-deterministic acquisitions start at once and let the delay run alongside
    // the first scan; deterministic ones hold in the pre-settle state until it ends.
    unique case (s_q.st)
      aic_pkg::AIC_IDLE: begin
        if (ACQ_START) begin
          // Total delay is the count times the number of measured ports.
          s_d.remain = 13'(CFG.aux_settle_count) * 13'(n_en);
          s_d.settle_done = (CFG.aux_settle_count == '0) || (n_en == 3'h0);
          s_d.pre_done = 1'b0;
          s_d.scan_seen = 1'b0;
          if (DETERMINISTIC) begin
            s_d.st = aic_pkg::AIC_PRE;
          end else begin
            s_d.st = aic_pkg::AIC_RUN;
            s_d.acq_go = 1'b1;
          end
        end
      end
      aic_pkg::AIC_PRE: begin
        if (s_q.settle_done) begin
          s_d.st = aic_pkg::AIC_RUN;
          s_d.acq_go = 1'b1;
        end
      end
      aic_pkg::AIC_RUN: begin
        // The first scan may finish long before the delay does, so it is remembered.
        if (FIRST_SCAN_DONE) begin
          s_d.scan_seen = 1'b1;
        end
        if ((FIRST_SCAN_DONE || s_q.scan_seen) && s_q.settle_done && !s_q.pre_done) begin
          s_d.pre_done = 1'b1;
          s_d.conv_start = 1'b1;
        end
        if (ACQ_END) begin
          s_d.st = aic_pkg::AIC_IDLE;
          s_d.settle_done = 1'b0;
        end
      end
    endcase
    // A tick on the cycle that ends the acquisition is ignored, so the done flag
    // cannot rise while idle.
    if (s_q.st != aic_pkg::AIC_IDLE && s_d.st != aic_pkg::AIC_IDLE &&
        !s_q.settle_done && tick) begin
      if (s_q.remain <= 13'h0001) begin
        s_d.remain = '0;
        s_d.settle_done = 1'b1;
      end else begin
        s_d.remain = s_q.remain - 13'h0001;
      end
    end

    // Automatic bias follows the next state, so the pin rises with the request.
    unique case (CFG.bias_output_mode)
      `AIC_BIAS_AUTO0, `AIC_BIAS_AUTO1: s_d.bias = (s_d.st != aic_pkg::AIC_IDLE);
      `AIC_BIAS_OFF: s_d.bias = 1'b0;
      `AIC_BIAS_ON: s_d.bias = 1'b1;
    endcase
    // A rewrite of the pin configuration clears the alerts, but an overvoltage in
    // the same cycle wins, so a fault is never lost.
    if (CFG_WRITE) begin
      s_d.alert = '0;
      s_d.open_path = '0;
    end
    s_d.alert = s_d.alert | (OVERVOLT & aux_sel);
    s_d.open_path = s_d.open_path | (OVERVOLT & aux_sel);
    s_d.alert_any = |s_d.alert;
    // Results carry the saturated code; channel numbers above five are dropped.
    if (CONV_VALID && CONV_CHANNEL < 3'(`AIC_NUM_PORTS)) begin
      s_d.result[CONV_CHANNEL] = pack_result(CONV_CODE);
    end
    if (CFG.i2c_pins_select) begin
      s_d.result[0] = `AIC_ZERO_RESULT;
      s_d.result[1] = `AIC_ZERO_RESULT;
    end
  end

  // Synchronous reset returns every field to zero, the idle state included.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
      s_q.st <= aic_pkg::AIC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign BIAS_OUTPUT_PIN = s_q.bias;
  assign SETTLE_DONE = s_q.settle_done;
  assign ACQ_GO = s_q.acq_go;
  assign AUX_CONV_START = s_q.conv_start;
  assign AUX_PATH_OPEN = s_q.open_path;
  assign AUX_MEASURE_ACTIVE = s_q.active;
  assign USE_ABSOLUTE_THRESH = s_q.absolute;
  assign GPIO_DRIVER_EN = s_q.gpio_drv;
  assign I2C_ENABLE = s_q.i2c;
  assign AUX_PROTECT_ALERT = s_q.alert;
  assign AUX_PROTECT_ALERT_ANY = s_q.alert_any;
  assign AUX_RESULT_REGISTER = s_q.result;
endmodule : aic_aux_ctrl

// ---- aic_checker.sv ----
// Port checker for the auxiliary input control block.
// Assumes it is bound to aic_aux_ctrl and that all ports match by name.
`timescale 1ns/1ps
module aic_checker (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire aic_pkg::aic_cfg_s CFG,
  input wire logic DETERMINISTIC,
  input wire logic ACQ_START,
  input wire logic [5:0] OVERVOLT,
  input wire logic BIAS_OUTPUT_PIN,
  input wire logic SETTLE_DONE,
  input wire logic ACQ_GO,
  input wire logic AUX_CONV_START,
  input wire logic [5:0] AUX_PATH_OPEN,
  input wire logic [5:0] GPIO_DRIVER_EN,
  input wire logic I2C_ENABLE,
  input wire logic [5:0] AUX_PROTECT_ALERT,
  input wire logic AUX_PROTECT_ALERT_ANY,
  input wire logic [95:0] AUX_RESULT_REGISTER
);
  // ****
  // Properties
  // ****
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence ov0;
    OVERVOLT[0] && CFG.measure_enable[0] && !CFG.gpio_select[0] && !CFG.i2c_pins_select;
  endsequence
  sequence nd_start;
    ACQ_START && !DETERMINISTIC;
  endsequence
  a_bias_on: assert property ((CFG.bias_output_mode == 2'h3)[*2] |-> BIAS_OUTPUT_PIN)
    else $error("bias pin low in static on mode");
  a_bias_off: assert property ((CFG.bias_output_mode == 2'h2)[*2] |-> !BIAS_OUTPUT_PIN)
    else $error("bias pin high in static off mode");
  a_low_zero: assert property ((AUX_RESULT_REGISTER & {6{16'h0003}}) == 96'h0)
    else $error("result low bits not zero");
  a_i2c_zero: assert property (CFG.i2c_pins_select[*2] |-> I2C_ENABLE && AUX_RESULT_REGISTER[31:0] == 32'h0)
    else $error("i2c mode wrong");
  a_gpio_tri: assert property ((!CFG.gpio_select[2])[*2] |-> !GPIO_DRIVER_EN[2])
    else $error("gpio driver not tristated");
  a_alert_set: assert property (ov0 |=> AUX_PROTECT_ALERT[0] && AUX_PATH_OPEN[0])
    else $error("overvoltage not latched");
  a_alert_any: assert property (AUX_PROTECT_ALERT != 6'h0 |-> ##[0:1] AUX_PROTECT_ALERT_ANY)
    else $error("summary alert missing");
  a_conv_settled: assert property (AUX_CONV_START |-> $past(SETTLE_DONE))
    else $error("conversion before settling");
  a_go_nondet: assert property (nd_start |-> ##[1:2] ACQ_GO)
    else $error("acquisition did not start");
  a_go_det: assert property (ACQ_GO && DETERMINISTIC |-> $past(SETTLE_DONE))
    else $error("deterministic start before settling");
endmodule : aic_checker
bind aic_aux_ctrl aic_checker aic_checker_i (.*);

// ---- aic_front_end.sv ----
// Model of the converter front end facing the block.
// Assumes one conversion per port follows each conversion start.
`timescale 1ns/1ps
module aic_front_end (
  input wire logic clk,
  input wire logic start,
  output logic valid = 1'b0,
  output logic [2:0] chan,
  output logic [14:0] code
);
  int n = 9;
  always @(posedge clk) begin
    if (start) n <= 0;
    else if (n < 9) n <= n + 1;
    valid <= n < 6;
    chan <= n[2:0];
    // Port five is driven past full scale; idle code toggles.
    code <= n == 5 ? 15'h4001 : n < 5 ? 15'(n * 14'hA01) : ~code;
  end
endmodule : aic_front_end

// ---- test_aic_aux_ctrl.sv ----
// Self-checking bench for the auxiliary input control block.
// Assumes the checker is bound and the front end model is compiled.
`timescale 1ns/1ps
module test_aic_aux_ctrl;
  logic CORE_CLK = 0, SYS_RST = 1, cfg_wr = 0, det = 0, start = 0, acq_end = 0, fsd = 0;
  aic_pkg::aic_cfg_s cfg = '0;
  logic [5:0] ov = 0, open_p, gpio_en, alert, abs_t, act;
  logic bias, sdone, go, cstart, i2c, any, cv;
  logic [95:0] res;
  logic [2:0] cch;
  logic [14:0] ccode;
  int fails = 0, checks = 0, cyc = 0, n;
  aic_aux_ctrl aic_aux_ctrl_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CFG(cfg),
    .CFG_WRITE(cfg_wr), .DETERMINISTIC(det), .ACQ_START(start), .ACQ_END(acq_end),
    .FIRST_SCAN_DONE(fsd), .CONV_VALID(cv), .CONV_CHANNEL(cch), .CONV_CODE(ccode),
    .OVERVOLT(ov), .BIAS_OUTPUT_PIN(bias), .SETTLE_DONE(sdone), .ACQ_GO(go),
    .AUX_CONV_START(cstart), .AUX_PATH_OPEN(open_p), .AUX_MEASURE_ACTIVE(act),
    .USE_ABSOLUTE_THRESH(abs_t), .GPIO_DRIVER_EN(gpio_en), .I2C_ENABLE(i2c),
    .AUX_PROTECT_ALERT(alert), .AUX_PROTECT_ALERT_ANY(any), .AUX_RESULT_REGISTER(res));
  aic_front_end aic_front_end_i (.clk(CORE_CLK), .start(cstart), .valid(cv), .chan(cch),
    .code(ccode));
  initial forever #2 CORE_CLK = ~CORE_CLK;
  task automatic chk(string nm, logic [95:0] exp, logic [95:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(negedge CORE_CLK);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask : pulse
  task automatic wait_for(ref logic s, output int k);
    k = 0;
    while (s !== 1'b1 && k < 12000) begin
      tick(1);
      k++;
    end
    if (s !== 1'b1) begin
      fails++;
      $display("wrong value wait exp 1 got %b", s);
    end
  endtask : wait_for
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    tick(4);
    SYS_RST = 0;
    chk("reset", 0, {i2c, alert, gpio_en, bias});
    for (int m = 0; m < 4; m++) begin
      cfg.bias_output_mode = 2'(m);
      tick(2);
      chk("bias idle", 96'(m == 3), bias);
    end
    cfg.bias_output_mode = 2'h0;
    cfg.aux_settle_count = 10'h001;
    cfg.measure_enable = 6'h3F;
    tick(1);
    pulse(start);
    chk("nd go", 1, go);
    pulse(fsd);
    chk("bias acq", 1, bias);
    wait_for(cstart, n);
    chk("settle", 3, {sdone, n > 7490 && n < 9010});
    tick(9);
    for (int c = 0; c < 5; c++) begin
      chk("result", {14'(c * 14'hA01), 2'h0}, res[16*c+:16]);
    end
    chk("saturate", 16'hFFFC, res[95:80]);
    pulse(acq_end);
    tick(2);
    chk("bias end", 0, {sdone, bias});
    cfg.measure_enable = 6'h08;
    det = 1;
    tick(1);
    pulse(start);
    wait_for(go, n);
    chk("det go", 7, {go, sdone, n > 1 && n < 1502});
    pulse(fsd);
    wait_for(cstart, n);
    chk("det conv", 3, {cstart, n == 0});
    tick(9);
    pulse(acq_end);
    det = 0;
    cfg.measure_enable = 6'h3F;
    cfg.i2c_pins_select = 1;
    tick(2);
    chk("i2c", {1'b1, 6'h00, 6'h3C, 32'h0}, {i2c, gpio_en, act, res[31:0]});
    cfg.i2c_pins_select = 0;
    cfg.gpio_select = 6'h05;
    tick(2);
    chk("gpio", {6'h05, 6'h3A}, {gpio_en, act});
    cfg.gpio_select = 6'h02;
    ov = 6'h03;
    tick(1);
    ov = 6'h00;
    tick(1);
    chk("alert", {1'b1, 6'h01, 6'h01}, {any, alert, open_p});
    pulse(cfg_wr);
    tick(1);
    chk("alert clr", 0, {any, alert, open_p});
    ov = 6'h01;
    pulse(cfg_wr);
    ov = 6'h00;
    chk("set wins", 7'h41, {any, alert});
    cfg.reference_select = 6'h0F;
    tick(2);
    chk("mixed", 6'h0F, abs_t);
    cfg.bias_output_mode = 2'h2;
    cfg.reference_select = 6'h3F;
    tick(2);
    chk("bias off", 0, bias);
    finish_test();
  end
endmodule : test_aic_aux_ctrl
